//--- hw/wml_params.svh
// Purpose: Named offsets, field positions, reset values and limits
// Assumes: Included by the package and the loader module
// Notes: Definitions only
`ifndef WML_PARAMS_SVH
`define WML_PARAMS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_SEG_LEN 8'h04
`define OFF_SEG_BASE 8'h08
`define OFF_DATA 8'h0C
`define OFF_STATUS 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_MASK 8'h18
`define OFF_CMD_RST 8'h1C
`define OFF_SEG_NUM 8'h20
// Field positions
`define CTRL_TGT_BIT 2
`define CTRL_PLAY_BIT 3
`define IRQ_LEN_ERR 0
`define IRQ_OVERRUN 1
`define IRQ_SEG_DONE 2
`define IRQ_W 3
// Widths and limits
`define SAMPLE_W 14
`define ADDR_W_DEF 25
`define GROUP_LOG 4
`define MIN_SEG_LEN 32'h000000C0
`define MAX_SEGS 32'h00004000
// Reset values
`define LEN_RST 32'h000000C0
`define MODE_RST 2'h1
`define SEG_NUM_RST 32'h00000001
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hw/waveform_pkg.sv
// Purpose: Types shared by the waveform loader files
// Assumes: wml_params.svh defines the sample width
// Notes: No constants live here, only types
`include "wml_params.svh"
`default_nettype none
package waveform_pkg;
   // Download modes, codes as software writes them
   typedef enum logic [1:0] {
      single_mode = 2'h0,
      copy_to_partner_mode = 2'h1,
      partner_cleared_mode = 2'h2,
      host_interleaved_mode = 2'h3
   } dl_mode_t;
   // Download engine, one-hot
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_read = 4'h2,
      st_target = 4'h4,
      st_partner = 4'h8
   } eng_state_t;
   // Replayed sample stream
   typedef struct packed {
      logic valid;
      logic even_chan;
      logic [`SAMPLE_W-1:0] sample;
   } play_t;
   // Sample handed to nonvolatile storage
   typedef struct packed {
      logic valid;
      logic [`SAMPLE_W-1:0] sample;
   } nv_t;
endpackage
`default_nettype wire

//--- hw/pair_memory.sv
// Purpose: Shared sample block of one channel pair
// Assumes: One clock, clock enable freezes everything
// Notes: Port A loads and reads back, port B replays; read data registered
`default_nettype none
module pair_memory #(
   parameter int ADDR_W = 25,
   parameter int DATA_W = 14
) (
   // Clock
   input wire logic aclk,
   input wire logic ce,
   // Load port
   input wire logic a_wr,
   input wire logic a_rd,
   input wire logic [ADDR_W-1:0] a_addr,
   input wire logic [DATA_W-1:0] a_wdata,
   output logic [DATA_W-1:0] a_rdata,
   // Replay port
   input wire logic b_rd,
   input wire logic [ADDR_W-1:0] b_addr,
   output logic [DATA_W-1:0] b_rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Load port: read data held until the next read
   always_ff @(posedge aclk) begin
      if (ce && a_wr) begin
         mem[a_addr] <= a_wdata;
      end
      if (ce && a_rd) begin
         a_rdata <= mem[a_addr];
      end
   end

   // Replay port
   always_ff @(posedge aclk) begin
      if (ce && b_rd) begin
         b_rdata <= mem[b_addr];
      end
   end
endmodule
`default_nettype wire

//--- hw/waveform_memory_loader.sv
// Purpose: Waveform loader and replay for one channel pair
// Assumes: AXI4-Lite register access, 100 MHz aclk, play_tick from aclk domain
// Notes: One pair block per instance; ADDR_W sets its depth
`include "wml_params.svh"
`default_nettype none
module waveform_memory_loader #(
   parameter int ADDR_W = `ADDR_W_DEF
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Sample clock enable and replay stream
   input wire logic play_tick,
   output waveform_pkg::play_t play,
   // Nonvolatile storage hand-off and interrupt
   output waveform_pkg::nv_t nv_store,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic wr_fire, rd_fire, wr_known, rd_known, data_wr, len_ok, num_ok;
   logic [31:0] wval, rd_word;
   logic [32:0] seg_end;
   waveform_pkg::dl_mode_t mode_reg;
   logic tgt_even_reg, play_en_reg;
   logic [ADDR_W-1:0] seg_len_reg, seg_base_reg, n_reg, n_limit, base_pair;
   logic [31:0] seg_num_reg;
   logic [`IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set, irq_clr;
   waveform_pkg::eng_state_t state_reg;
   logic [`SAMPLE_W-1:0] sample_reg;
   logic a_wr, a_rd, b_rd;
   logic [ADDR_W-1:0] a_addr, b_addr, tgt_addr, partner_addr, p_reg;
   logic [`SAMPLE_W-1:0] a_wdata, a_rdata, b_rdata;
   logic busy, last_point, play_valid_reg, play_even_reg;
   logic nv_valid_reg;

   // Byte-lane merge of a register write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data taken in either order
   assign awready = !aw_held_reg;
   assign wready = !w_held_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   // A data write waits for the engine, which back-pressures the host
   assign data_wr = aw_addr_reg == `OFF_DATA;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg && !(data_wr && busy);

   // Address holding register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   // Data holding register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Known write offsets; others answer SLVERR and store nothing
   always_comb begin
      case (aw_addr_reg)
         `OFF_CTRL, `OFF_SEG_LEN, `OFF_SEG_BASE, `OFF_DATA, `OFF_IRQ_STAT,
         `OFF_IRQ_MASK, `OFF_CMD_RST, `OFF_SEG_NUM: wr_known = 1'b1;
         default: wr_known = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   assign wval = w_data_reg;
   // Length must be legal and the segment must fit in one channel half
   assign seg_end = 33'(seg_base_reg) + 33'(wval[ADDR_W-1:0]);
   assign len_ok = wval >= `MIN_SEG_LEN && wval[`GROUP_LOG-1:0] == 4'h0
                   && wval[31:ADDR_W] == '0 && seg_end <= (33'h1 << (ADDR_W - 1));
   assign num_ok = wval != 32'h00000000 && wval <= `MAX_SEGS;

   // Mode, channel select and replay enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= waveform_pkg::dl_mode_t'(`MODE_RST);
         tgt_even_reg <= 1'b0;
         play_en_reg <= 1'b0;
      end else if (ce && wr_fire) begin
         if (aw_addr_reg == `OFF_CTRL) begin
            if (w_strb_reg[0]) begin
               mode_reg <= waveform_pkg::dl_mode_t'(wval[1:0]);
               tgt_even_reg <= wval[`CTRL_TGT_BIT];
               play_en_reg <= wval[`CTRL_PLAY_BIT];
            end
         end else if (aw_addr_reg == `OFF_CMD_RST) begin
            mode_reg <= waveform_pkg::dl_mode_t'(`MODE_RST);
            play_en_reg <= 1'b0;
         end
      end
   end

   // One length for both channels of the pair; illegal values are refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seg_len_reg <= ADDR_W'(`LEN_RST);
         seg_base_reg <= '0;
         seg_num_reg <= `SEG_NUM_RST;
      end else if (ce && wr_fire) begin
         if (aw_addr_reg == `OFF_SEG_LEN && len_ok) begin
            seg_len_reg <= wval[ADDR_W-1:0];
         end
         if (aw_addr_reg == `OFF_SEG_BASE) begin
            seg_base_reg <= ADDR_W'(merge(32'(seg_base_reg), wval, w_strb_reg) & ~32'h0000000F);
         end
         if (aw_addr_reg == `OFF_SEG_NUM && num_ok) begin
            seg_num_reg <= wval;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Download engine
   assign busy = state_reg != waveform_pkg::st_idle;
   // Host_interleaved_mode streams cover both halves, so twice the points per segment
   assign n_limit = mode_reg == waveform_pkg::host_interleaved_mode ? seg_len_reg << 1 : seg_len_reg;
   assign last_point = n_reg == n_limit - 1'b1;
   assign base_pair = seg_base_reg << 1;
   // Even channel takes the lower group of each 32-point pair of groups
   assign tgt_addr = base_pair + {n_reg[ADDR_W-2:`GROUP_LOG], !tgt_even_reg,
                                  n_reg[`GROUP_LOG-1:0]};
   assign partner_addr = base_pair + {n_reg[ADDR_W-2:`GROUP_LOG], tgt_even_reg,
                                      n_reg[`GROUP_LOG-1:0]};

   // Engine sequencing per sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= waveform_pkg::st_idle;
         sample_reg <= '0;
         n_reg <= '0;
      end else if (ce) begin
         case (state_reg)
            waveform_pkg::st_idle: begin
               if (wr_fire && aw_addr_reg == `OFF_SEG_LEN || wr_fire && aw_addr_reg == `OFF_SEG_BASE) begin
                  n_reg <= '0;
               end else if (wr_fire && data_wr && n_reg < n_limit) begin
                  sample_reg <= wval[`SAMPLE_W-1:0];
                  if (mode_reg == waveform_pkg::single_mode) begin
                     state_reg <= waveform_pkg::st_read;
                  end else begin
                     state_reg <= waveform_pkg::st_target;
                  end
               end
            end
            waveform_pkg::st_read: begin
               state_reg <= waveform_pkg::st_target;
            end
            waveform_pkg::st_target: begin
               if (mode_reg == waveform_pkg::host_interleaved_mode) begin
                  state_reg <= waveform_pkg::st_idle;
                  n_reg <= last_point ? '0 : n_reg + 1'b1;
               end else begin
                  state_reg <= waveform_pkg::st_partner;
               end
            end
            waveform_pkg::st_partner: begin
               state_reg <= waveform_pkg::st_idle;
               n_reg <= last_point ? '0 : n_reg + 1'b1;
            end
            default: begin
               state_reg <= waveform_pkg::st_idle;
            end
         endcase
      end
   end

   // Load port drive; partner read is issued two cycles before its use
   always_comb begin
      a_wr = 1'b0;
      a_rd = 1'b0;
      a_addr = tgt_addr;
      a_wdata = sample_reg;
      case (state_reg)
         waveform_pkg::st_read: begin
            a_rd = 1'b1;
            a_addr = partner_addr;
         end
         waveform_pkg::st_target: begin
            a_wr = 1'b1;
            if (mode_reg == waveform_pkg::host_interleaved_mode) begin
               a_addr = base_pair + n_reg;
            end
         end
         waveform_pkg::st_partner: begin
            a_wr = 1'b1;
            a_addr = partner_addr;
            case (mode_reg)
               waveform_pkg::copy_to_partner_mode: a_wdata = sample_reg;
               waveform_pkg::partner_cleared_mode: a_wdata = '0;
               default: a_wdata = a_rdata;
            endcase
         end
         default: begin
            a_wr = 1'b0;
         end
      endcase
   end

   // Single mode hands each sample to nonvolatile storage before the block rewrite
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nv_valid_reg <= 1'b0;
      end else if (ce) begin
         nv_valid_reg <= state_reg == waveform_pkg::st_idle && wr_fire && data_wr
                         && n_reg < n_limit && mode_reg == waveform_pkg::single_mode;
      end
   end
   assign nv_store = '{valid: nv_valid_reg, sample: sample_reg};

   ////////////////////////////////////////////////////////////////////////////
   // Replay: pair block walked upward, one point per sample tick
   assign b_rd = play_en_reg && play_tick;
   assign b_addr = base_pair + p_reg;

   // Replay pointer wraps at the segment end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p_reg <= '0;
         play_valid_reg <= 1'b0;
         play_even_reg <= 1'b0;
      end else if (ce) begin
         play_valid_reg <= b_rd;
         if (!play_en_reg) begin
            p_reg <= '0;
         end else if (play_tick) begin
            play_even_reg <= !p_reg[`GROUP_LOG];
            p_reg <= p_reg == (seg_len_reg << 1) - 1'b1 ? '0 : p_reg + 1'b1;
         end
      end
   end
   assign play = '{valid: play_valid_reg, even_chan: play_even_reg, sample: b_rdata};

   // Shared pair block; depth fixed by ADDR_W (25 standard, 26 option)
   pair_memory #(
      .ADDR_W(ADDR_W),
      .DATA_W(`SAMPLE_W)
   ) u_mem (
      .aclk(aclk),
      .ce(ce),
      .a_wr(a_wr),
      .a_rd(a_rd),
      .a_addr(a_addr),
      .a_wdata(a_wdata),
      .a_rdata(a_rdata),
      .b_rd(b_rd),
      .b_addr(b_addr),
      .b_rdata(b_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status; a new event wins over a clear in the same cycle
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_LEN_ERR] = wr_fire && (aw_addr_reg == `OFF_SEG_LEN && !len_ok
                              || aw_addr_reg == `OFF_SEG_NUM && !num_ok);
      irq_set[`IRQ_OVERRUN] = wr_fire && data_wr && n_reg >= n_limit;
      irq_set[`IRQ_SEG_DONE] = last_point && (state_reg == waveform_pkg::st_partner
                               || state_reg == waveform_pkg::st_target
                               && mode_reg == waveform_pkg::host_interleaved_mode);
      irq_clr = '0;
      if (wr_fire && aw_addr_reg == `OFF_IRQ_STAT && w_strb_reg[0]) begin
         irq_clr = wval[`IRQ_W-1:0];
      end
   end

   // Status and mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else if (ce) begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (wr_fire && aw_addr_reg == `OFF_IRQ_MASK && w_strb_reg[0]) begin
            irq_mask_reg <= wval[`IRQ_W-1:0];
         end
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   assign arready = !rvalid_reg;
   assign rd_fire = arvalid && arready;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // Read mux; unused bits read zero
   always_comb begin
      rd_known = 1'b1;
      rd_word = 32'h00000000;
      case (araddr)
         `OFF_CTRL: rd_word = {28'h0000000, play_en_reg, tgt_even_reg, mode_reg};
         `OFF_SEG_LEN: rd_word = 32'(seg_len_reg);
         `OFF_SEG_BASE: rd_word = 32'(seg_base_reg);
         `OFF_STATUS: rd_word = {(32'(n_reg) << 4) | {30'h00000000, play_en_reg, busy}};
         `OFF_IRQ_STAT: rd_word = 32'(irq_stat_reg);
         `OFF_IRQ_MASK: rd_word = 32'(irq_mask_reg);
         `OFF_SEG_NUM: rd_word = seg_num_reg;
         `OFF_DATA, `OFF_CMD_RST: rd_word = 32'h00000000;
         default: rd_known = 1'b0;
      endcase
   end

   // Read data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/wml_chk.sv
// Purpose: Port checks for the waveform loader
// Assumes: One clock domain, ce held high
// Notes: Bound into every loader instance
`default_nettype none
module wml_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Streams
   input wire logic play_tick,
   input wire waveform_pkg::play_t play,
   input wire waveform_pkg::nv_t nv_store,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////
   // Outputs idle on the first edge out of reset
   property p_rst; $rose(aresetn) |-> !irq && !bvalid && !rvalid && !play.valid; endproperty
   a_rst: assert property (p_rst) else $error("outputs busy after reset");
   // A replayed sample only ever follows a tick
   property p_play; play.valid |-> $past(play_tick); endproperty
   a_play: assert property (p_play) else $error("sample without tick");
   // Store hand-off belongs to a data write being answered
   property p_nv; nv_store.valid |-> ##[0:3] bvalid; endproperty
   a_nv: assert property (p_nv) else $error("store pulse without write");
   property p_nvp; nv_store.valid |=> !nv_store.valid; endproperty
   a_nvp: assert property (p_nvp) else $error("store pulse too long");
   // Answers stand until taken
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_ar; arvalid && arready |=> rvalid; endproperty
   a_ar: assert property (p_ar) else $error("read answer late");
   // Busy engine may delay the answer by two cycles at most
   property p_aw; awvalid && awready && wvalid && wready |-> ##[1:4] bvalid; endproperty
   a_aw: assert property (p_aw) else $error("write answer late");
   c_odd: cover property (play.valid && !play.even_chan);
   c_nv: cover property (nv_store.valid);
   c_err: cover property (bvalid && bresp == 2'h2);
endmodule
bind waveform_memory_loader wml_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .play_tick(play_tick), .play(play), .nv_store(nv_store), .irq(irq)
);
`default_nettype wire

//--- tb/wml_host.sv
// Purpose: Remote host as a register bus master
// Assumes: Slave answers in its own time
// Notes: One transfer at a time; released data shows inverted
`default_nettype none
module wml_host (
   // Clock
   input wire logic aclk,
   // Write side
   output logic awvalid,
   output logic [7:0] awaddr,
   output logic wvalid,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic bready,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   // Read side
   output logic arvalid,
   output logic [7:0] araddr,
   output logic rready,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
   end
   ////////////////////////////////////////////////////////////
   // Address and data go out together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end while (!(bvalid && bready));
      bready <= 1'b0;
      r = bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
endmodule
`default_nettype wire

//--- tb/waveform_memory_loader_tb.sv
// Purpose: Self-checking bench for the waveform loader
// Assumes: Small pair block, base 0, length 192
// Notes: Replay reads the whole 384-point segment back to judge each mode
`include "wml_params.svh"
`default_nettype none
module waveform_memory_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, play_tick = 1'b0;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   waveform_pkg::play_t play;
   waveform_pkg::nv_t nv_store;
   logic [13:0] exp_mem [384];
   int n_errors = 0, num_checks = 0, nv_count = 0, cycles = 0;
   waveform_memory_loader #(.ADDR_W(10)) DUT (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .play_tick(play_tick), .play(play), .nv_store(nv_store), .irq(irq)
   );
   wml_host HOST (
      .aclk(aclk), .awvalid(awvalid), .awaddr(awaddr), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb),
      .bready(bready), .awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp), .arvalid(arvalid),
      .araddr(araddr), .rready(rready), .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp)
   );
   always #5 aclk = ~aclk;
   // Hang guard; a full run needs about 7k cycles
   always @(posedge aclk) begin
      cycles++;
      // Only the single-mode load (seed 3) hands samples to storage
      if (nv_store.valid === 1'b1) begin
         check("nv_sample", 32'(val(3, nv_count)), 32'(nv_store.sample));
         nv_count++;
      end
      if (cycles == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Seed 0 means all-zero samples
   function automatic logic [13:0] val(int seed, int n);
      return (seed == 0) ? 14'h0000 : 14'((n * 37 + seed * 101) % 16384);
   endfunction
   // Even channel owns the lower group of each 32-word stripe
   function automatic void fill(int se, int so);
      for (int p = 0; p < 384; p++) begin
         exp_mem[p] = ((p / 16) % 2 == 0) ? val(se, (p / 32) * 16 + p % 16) : val(so, (p / 32) * 16 + p % 16);
      end
   endfunction
   task automatic load(logic [1:0] mode, logic even, int seed, int cnt);
      HOST.wr(`OFF_CTRL, {28'h0, 1'b0, even, mode}, resp);
      for (int n = 0; n < cnt; n++) begin
         HOST.wr(`OFF_DATA, {18'h0, val(seed, n)}, resp);
      end
      // Engine settles within four edges of the last accept
      repeat (5) @(posedge aclk);
   endtask
   task automatic replay(string what);
      int k;
      HOST.wr(`OFF_CTRL, 32'h00000008, resp);
      for (int p = 0; p < 384; p++) begin
         @(posedge aclk) play_tick <= 1'b1;
         @(posedge aclk) play_tick <= 1'b0;
         k = 0;
         while (play.valid !== 1'b1 && k < 4) begin
            @(negedge aclk);
            k++;
         end
         check(what, {16'h0, 1'b1, (p / 16) % 2 == 0, exp_mem[p]}, {16'h0, play});
      end
      HOST.wr(`OFF_CTRL, 32'h00000000, resp);
      $display("test %s done", what);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      HOST.rd(`OFF_CTRL, rd_data, resp);
      check("ctrl", 32'h00000001, rd_data & 32'h0000000F);
      HOST.rd(`OFF_SEG_LEN, rd_data, resp);
      check("seg_len", 32'h000000C0, rd_data);
      HOST.rd(`OFF_SEG_NUM, rd_data, resp);
      check("seg_num", 32'h00000001, rd_data);
      HOST.rd(8'h24, rd_data, resp);
      check("unmapped", 32'h00000002, {30'h0, resp});
      HOST.wr(8'h24, 32'h00000000, resp);
      check("unmapped_wr", 32'h00000002, {30'h0, resp});
      $display("test reset done");
   endtask
   task automatic t_length();
      HOST.wr(`OFF_IRQ_MASK, 32'h00000001, resp);
      HOST.wr(`OFF_SEG_LEN, 32'h000000C8, resp);
      HOST.rd(`OFF_SEG_LEN, rd_data, resp);
      check("len_kept", 32'h000000C0, rd_data);
      check("irq_on", 32'h00000001, {31'h0, irq});
      HOST.wr(`OFF_IRQ_STAT, 32'h00000007, resp);
      check("irq_off", 32'h00000000, {31'h0, irq});
      HOST.wr(`OFF_SEG_LEN, 32'h000000B0, resp);
      HOST.rd(`OFF_IRQ_STAT, rd_data, resp);
      check("short_len", 32'h00000001, rd_data & 32'h00000001);
      HOST.wr(`OFF_IRQ_STAT, 32'h00000007, resp);
      $display("test length done");
   endtask
   task automatic t_dup();
      HOST.wr(`OFF_IRQ_MASK, 32'h00000004, resp);
      load(2'h1, 1'b1, 1, 192);
      fill(1, 1);
      check("seg_done", 32'h00000001, {31'h0, irq});
      HOST.wr(`OFF_IRQ_STAT, 32'h00000004, resp);
      check("done_clr", 32'h00000000, {31'h0, irq});
      replay("dup");
   endtask
   task automatic t_single();
      nv_count = 0;
      load(2'h0, 1'b0, 3, 192);
      fill(2, 3);
      check("nv_count", 32'h000000C0, nv_count);
      replay("single");
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_length();
      t_dup();
      load(2'h2, 1'b1, 2, 192);
      fill(2, 0);
      replay("zero");
      t_single();
      load(2'h3, 1'b1, 4, 384);
      for (int p = 0; p < 384; p++) exp_mem[p] = val(4, p);
      replay("comb");
      HOST.wr(`OFF_CTRL, 32'h0000000B, resp);
      HOST.wr(`OFF_CMD_RST, 32'h00000001, resp);
      HOST.rd(`OFF_CTRL, rd_data, resp);
      check("cmd_rst", 32'h00000001, rd_data & 32'h0000000B);
      $display("test cmd_rst done");
      finish_test();
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
